// *** design/ptt_pkg.sv ***
// constants for the protection and transient tuning register bank
// assumes a 10 MHz core clock and a command port fed by the management bus engine
package ptt_pkg;

   localparam int unsigned CLK_MHZ = 10;

   // command codes
   localparam logic [7:0] CODE_FAULT_MASK  = 8'hdf;
   localparam logic [7:0] CODE_UV_CONFIG   = 8'he1;
   localparam logic [7:0] CODE_PS_OFFSETS  = 8'he2;
   localparam logic [7:0] CODE_TUNING      = 8'he3;
   localparam logic [7:0] CODE_ZERO_TRIM   = 8'he4;

   // implemented bits of each register
   localparam logic [15:0] MASK_FAULT_MASK = 16'h01ff;
   localparam logic [15:0] MASK_UV_CONFIG  = 16'h007f;
   localparam logic [15:0] MASK_PS_OFFSETS = 16'h07ff;
   localparam logic [15:0] MASK_TUNING     = 16'h3fff;
   localparam logic [15:0] MASK_ZERO_TRIM  = 16'h001f;
   localparam logic [15:0] RST_REG         = 16'h0000;

   // fault mask bit positions
   localparam int unsigned FB_HIGH_OUTPUT_TRIP       = 0;
   localparam int unsigned FB_INPUT_OVERCURRENT      = 1;
   localparam int unsigned FB_SENSED_CURRENT_OC      = 2;
   localparam int unsigned FB_MONITOR_VOLTAGE_OC     = 3;
   localparam int unsigned FB_PER_PHASE_LIMIT        = 4;
   localparam int unsigned FB_LOW_OUTPUT_TRIP        = 5;
   localparam int unsigned FB_OVER_TEMPERATURE       = 6;
   localparam int unsigned FB_HIGH_OUTPUT_WARNING    = 7;
   localparam int unsigned FB_LOW_OUTPUT_WARNING     = 8;
   localparam int unsigned FAULT_COUNT               = 9;

   // undervoltage config fields
   localparam int unsigned UV_LEVEL_LSB  = 0;
   localparam int unsigned UV_DELAY_LSB  = 4;
   localparam int unsigned UV_ACTION_BIT = 6;

   // power state offset fields
   localparam int unsigned PS_DCM_LSB    = 0;
   localparam int unsigned PS_CLAMP_LSB  = 3;
   localparam int unsigned PS_DECAY_BIT  = 5;
   localparam int unsigned PS_LOWEST_LSB = 6;
   localparam int unsigned PS_FULL_LSB   = 9;

   // tuning fields, per phase group stride 3
   localparam int unsigned TU_STRIDE     = 3;
   localparam int unsigned TU_DECAY_OFS  = 1;
   localparam int unsigned TU_PEAK_LSB   = 9;
   localparam int unsigned TU_HPASS_LSB  = 11;
   localparam int unsigned TU_GAIN_BIT   = 13;

   // voltages in mV
   localparam int unsigned LOW_OUTPUT_WARNING_ABOVE_MV  = 66;
   localparam int unsigned OFFSET_STEP_MV    = 20;
   localparam int unsigned DECAY_OFS_LO_MV   = 100;
   localparam int unsigned DECAY_OFS_HI_MV   = 200;
   localparam logic [1:0]  SPEEDUP_ORIGINAL  = 2'h0;

   // persistence times in us and their cycle counts
   localparam int unsigned UV_DLY0_US = 10;
   localparam int unsigned UV_DLY1_US = 20;
   localparam int unsigned UV_DLY2_US = 40;
   localparam int unsigned UV_DLY3_US = 120;
   localparam int unsigned UV_DLY0_CYC = UV_DLY0_US * CLK_MHZ;
   localparam int unsigned UV_DLY1_CYC = UV_DLY1_US * CLK_MHZ;
   localparam int unsigned UV_DLY2_CYC = UV_DLY2_US * CLK_MHZ;
   localparam int unsigned UV_DLY3_CYC = UV_DLY3_US * CLK_MHZ;
   localparam int unsigned DLY_W = 11;

   // decay codes as presented to the loop
   typedef enum logic [1:0] {
      PTT_DECAY_HALF    = 2'b00,
      PTT_DECAY_NORMAL  = 2'b01,
      PTT_DECAY_QUARTER = 2'b10
   } ptt_decay_t;

   typedef enum logic [1:0] {
      PTT_PS_FULL    = 2'b00,
      PTT_PS_REDUCED = 2'b01,
      PTT_PS_LOWEST  = 2'b10
   } ptt_pstate_t;

endpackage

// *** design/ptt_regs.sv ***
// protection and transient tuning register bank with its protection gating
// assumes a bus engine presenting decoded command codes, an nvm loader, and async comparator levels
//
// Contract
// - nine-bit mask, one bit per protection; set bit disables it
// - undervoltage bits 3:0 select trip level 105 to 402 mV
// - trip at reference minus level; warning sits 66 mV above trip
// - undervoltage trip and warning suppressed when their mask bits set
// - bits 5:4 select persistence 10, 20, 40 or 120 us
// - bit 6 chooses monitor only or hiccup restart
// - bits 2:0 hold discontinuous-mode offset, 20 mV steps, unused
// - bits 4:3 set compensation bottom clamp 20 to 80 mV
// - bit 5 selects decay offset 100 or 200 mV, unused
// - bits 8:6 give offset on active to lowest-state transition
// - bits 10:9 give offset on reduced to full transition only
// - three power states: lowest, reduced, full; code 3 unused
// - per-phase tuning acts only when speed-up selection is original
// - bits 0, 3, 6 pick reduced dead band per phase group
// - bit pairs pick decay: 0 and 3 half, 1 normal, 2 quarter
// - bits 10:9 select peak-detect capacitance 1 to 4 pF
// - bits 12:11 select high-pass capacitance 1 to 4 pF
// - bit 13 doubles high-frequency balance gain
// - bits 4:0 signed monitor trim in 0.25 uA steps
// - nvm defaults load from the bank the select field names
module ptt_regs (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        cmd_write,
   input  wire logic        cmd_read,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [15:0] cmd_wdata,
   output logic      [15:0] cmd_rdata,
   output logic             cmd_ack,
   output logic             cmd_unmapped,
   input  wire logic [2:0]  nonvolatile_bank_select,
   input  wire logic        nvm_load_start,
   input  wire logic        nvm_load_valid,
   input  wire logic [7:0]  nvm_load_code,
   input  wire logic [15:0] nvm_load_data,
   output logic      [2:0]  nvm_load_bank,
   input  wire logic [8:0]  raw_fault,
   output logic      [8:0]  fault_active,
   output logic             low_output_trip_event,
   output logic             hiccup_request,
   output logic      [8:0]  low_output_trip_mv,
   output logic      [8:0]  low_output_warning_level_mv,
   input  wire logic [2:0]  speedup_sel,
   input  wire logic [1:0]  power_state,
   input  wire logic [2:0]  active_phase_count,
   output logic      [7:0]  discontinuous_mode_offset_mv,
   output logic      [6:0]  compensation_voltage_clamp_mv,
   output logic      [7:0]  decay_comp_offset_mv,
   output logic      [7:0]  transition_offset_mv,
   output logic             transition_offset_pulse,
   output logic             dead_band_reduced,
   output logic      [1:0]  decay_select,
   output logic      [2:0]  peak_detect_cap_pf,
   output logic      [2:0]  high_pass_cap_pf,
   output logic             balance_gain_double,
   output logic      [4:0]  current_monitor_pin_trim
);

   ////////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic [15:0] impl_mask(input logic [7:0] code);
      if (code == ptt_pkg::CODE_FAULT_MASK) begin
         impl_mask = ptt_pkg::MASK_FAULT_MASK;
      end else if (code == ptt_pkg::CODE_UV_CONFIG) begin
         impl_mask = ptt_pkg::MASK_UV_CONFIG;
      end else if (code == ptt_pkg::CODE_PS_OFFSETS) begin
         impl_mask = ptt_pkg::MASK_PS_OFFSETS;
      end else if (code == ptt_pkg::CODE_TUNING) begin
         impl_mask = ptt_pkg::MASK_TUNING;
      end else if (code == ptt_pkg::CODE_ZERO_TRIM) begin
         impl_mask = ptt_pkg::MASK_ZERO_TRIM;
      end else begin
         impl_mask = 16'h0000;
      end
   endfunction

   function automatic logic is_mapped(input logic [7:0] code);
      is_mapped = (impl_mask(code) != 16'h0000);
   endfunction

   // level below reference; codes above 7h hold the top level
   function automatic logic [8:0] uv_level_mv(input logic [3:0] code);
      case (code)
         4'h0: uv_level_mv = 9'h069;
         4'h1: uv_level_mv = 9'h08d;
         4'h2: uv_level_mv = 9'h0b2;
         4'h3: uv_level_mv = 9'h0d6;
         4'h4: uv_level_mv = 9'h0fc;
         4'h5: uv_level_mv = 9'h123;
         4'h6: uv_level_mv = 9'h148;
         default: uv_level_mv = 9'h192;
      endcase
   endfunction

   function automatic logic [7:0] step_mv(input logic [2:0] code);
      step_mv = 8'(code * ptt_pkg::OFFSET_STEP_MV);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [15:0] fault_check_mask_q;
   logic [15:0] undervolt_trip_config_q;
   logic [15:0] power_state_transition_offsets_q;
   logic [15:0] phase_count_transient_tuning_q;
   logic [15:0] current_monitor_zero_trim_q;

   logic        ld_en;
   logic [7:0]  wr_code;
   logic [15:0] wr_data;

   // nvm load takes priority over a host write in the same cycle
   assign ld_en   = nvm_load_valid | cmd_write;
   assign wr_code = nvm_load_valid ? nvm_load_code : cmd_code;
   assign wr_data = (nvm_load_valid ? nvm_load_data : cmd_wdata) & impl_mask(wr_code);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fault_check_mask_q               <= ptt_pkg::RST_REG;
         undervolt_trip_config_q          <= ptt_pkg::RST_REG;
         power_state_transition_offsets_q <= ptt_pkg::RST_REG;
         phase_count_transient_tuning_q   <= ptt_pkg::RST_REG;
         current_monitor_zero_trim_q      <= ptt_pkg::RST_REG;
      end else if (ld_en) begin
         if (wr_code == ptt_pkg::CODE_FAULT_MASK) begin
            fault_check_mask_q <= wr_data;
         end else if (wr_code == ptt_pkg::CODE_UV_CONFIG) begin
            undervolt_trip_config_q <= wr_data;
         end else if (wr_code == ptt_pkg::CODE_PS_OFFSETS) begin
            power_state_transition_offsets_q <= wr_data;
         end else if (wr_code == ptt_pkg::CODE_TUNING) begin
            phase_count_transient_tuning_q <= wr_data;
         end else if (wr_code == ptt_pkg::CODE_ZERO_TRIM) begin
            current_monitor_zero_trim_q <= wr_data;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         nvm_load_bank <= 3'h0;
      end else if (nvm_load_start) begin
         nvm_load_bank <= nonvolatile_bank_select;
      end
   end

   // read path, answer one cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmd_rdata    <= 16'h0000;
         cmd_ack      <= 1'b0;
         cmd_unmapped <= 1'b0;
      end else begin
         cmd_ack      <= cmd_read | cmd_write;
         cmd_unmapped <= (cmd_read | cmd_write) & ~is_mapped(cmd_code);
         if (cmd_read) begin
            if (cmd_code == ptt_pkg::CODE_FAULT_MASK) begin
               cmd_rdata <= fault_check_mask_q;
            end else if (cmd_code == ptt_pkg::CODE_UV_CONFIG) begin
               cmd_rdata <= undervolt_trip_config_q;
            end else if (cmd_code == ptt_pkg::CODE_PS_OFFSETS) begin
               cmd_rdata <= power_state_transition_offsets_q;
            end else if (cmd_code == ptt_pkg::CODE_TUNING) begin
               cmd_rdata <= phase_count_transient_tuning_q;
            end else if (cmd_code == ptt_pkg::CODE_ZERO_TRIM) begin
               cmd_rdata <= current_monitor_zero_trim_q;
            end else begin
               cmd_rdata <= 16'h0000;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault input synchronisers and masking

   logic [8:0] sync1_q;
   logic [8:0] sync2_q;
   logic [8:0] sync3_q;
   logic [8:0] fault_level_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_q <= 9'h000;
         sync2_q <= 9'h000;
         sync3_q <= 9'h000;
      end else begin
         sync1_q <= raw_fault;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < ptt_pkg::FAULT_COUNT; gi++) begin : g_fault
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               fault_level_q[gi] <= 1'b0;
            end else if (sync2_q[gi] == sync3_q[gi]) begin
               fault_level_q[gi] <= sync3_q[gi];
            end
         end
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               fault_active[gi] <= 1'b0;
            end else begin
               fault_active[gi] <= fault_level_q[gi] & ~fault_check_mask_q[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // undervoltage levels, persistence and response

   logic [3:0]             uv_code;
   logic [1:0]             uv_dly_code;
   logic [ptt_pkg::DLY_W-1:0] uv_dly_lim;
   logic [ptt_pkg::DLY_W-1:0] uv_cnt_q;
   logic                   uv_cond;

   assign uv_code     = undervolt_trip_config_q[ptt_pkg::UV_LEVEL_LSB +: 4];
   assign uv_dly_code = undervolt_trip_config_q[ptt_pkg::UV_DELAY_LSB +: 2];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         low_output_trip_mv          <= 9'h000;
         low_output_warning_level_mv <= 9'h000;
      end else begin
         low_output_trip_mv          <= uv_level_mv(uv_code);
         low_output_warning_level_mv <= uv_level_mv(uv_code) - 9'(ptt_pkg::LOW_OUTPUT_WARNING_ABOVE_MV);
      end
   end

   always_comb begin
      case (uv_dly_code)
         2'h0: uv_dly_lim = ptt_pkg::DLY_W'(ptt_pkg::UV_DLY0_CYC);
         2'h1: uv_dly_lim = ptt_pkg::DLY_W'(ptt_pkg::UV_DLY1_CYC);
         2'h2: uv_dly_lim = ptt_pkg::DLY_W'(ptt_pkg::UV_DLY2_CYC);
         default: uv_dly_lim = ptt_pkg::DLY_W'(ptt_pkg::UV_DLY3_CYC);
      endcase
   end

   assign uv_cond = fault_level_q[ptt_pkg::FB_LOW_OUTPUT_TRIP]
                    & ~fault_check_mask_q[ptt_pkg::FB_LOW_OUTPUT_TRIP];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         uv_cnt_q <= '0;
      end else if (!uv_cond) begin
         uv_cnt_q <= '0;
      end else if (uv_cnt_q < uv_dly_lim) begin
         uv_cnt_q <= uv_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         low_output_trip_event <= 1'b0;
         hiccup_request        <= 1'b0;
      end else begin
         low_output_trip_event <= uv_cond & (uv_cnt_q >= uv_dly_lim);
         hiccup_request        <= uv_cond & (uv_cnt_q >= uv_dly_lim) & ~low_output_trip_event
                                  & undervolt_trip_config_q[ptt_pkg::UV_ACTION_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power state offsets

   logic [1:0] ps_prev_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ps_prev_q <= ptt_pkg::PTT_PS_FULL;
      end else begin
         ps_prev_q <= power_state;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         discontinuous_mode_offset_mv  <= 8'h00;
         compensation_voltage_clamp_mv <= 7'h00;
         decay_comp_offset_mv          <= 8'h00;
      end else begin
         discontinuous_mode_offset_mv  <= step_mv(power_state_transition_offsets_q[ptt_pkg::PS_DCM_LSB +: 3]);
         compensation_voltage_clamp_mv <= 7'(step_mv({1'b0, power_state_transition_offsets_q[ptt_pkg::PS_CLAMP_LSB +: 2]})
                                          + 8'(ptt_pkg::OFFSET_STEP_MV));
         decay_comp_offset_mv          <= power_state_transition_offsets_q[ptt_pkg::PS_DECAY_BIT]
                                          ? 8'(ptt_pkg::DECAY_OFS_HI_MV) : 8'(ptt_pkg::DECAY_OFS_LO_MV);
      end
   end

   // momentary offset on the two transitions
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         transition_offset_mv    <= 8'h00;
         transition_offset_pulse <= 1'b0;
      end else if (power_state == ptt_pkg::PTT_PS_LOWEST && ps_prev_q != ptt_pkg::PTT_PS_LOWEST) begin
         transition_offset_mv    <= step_mv(power_state_transition_offsets_q[ptt_pkg::PS_LOWEST_LSB +: 3]);
         transition_offset_pulse <= 1'b1;
      end else if (power_state == ptt_pkg::PTT_PS_FULL && ps_prev_q == ptt_pkg::PTT_PS_REDUCED) begin
         transition_offset_mv    <= step_mv({1'b0, power_state_transition_offsets_q[ptt_pkg::PS_FULL_LSB +: 2]});
         transition_offset_pulse <= 1'b1;
      end else begin
         transition_offset_mv    <= 8'h00;
         transition_offset_pulse <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per phase count transient tuning

   logic [1:0] grp;
   logic       tune_on;
   logic [1:0] raw_decay;

   assign grp = (active_phase_count <= 3'h1) ? 2'h0 : (active_phase_count == 3'h2) ? 2'h1 : 2'h2;
   assign tune_on = (speedup_sel == 3'h0);
   assign raw_decay = phase_count_transient_tuning_q[grp * ptt_pkg::TU_STRIDE + ptt_pkg::TU_DECAY_OFS +: 2];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dead_band_reduced   <= 1'b0;
         decay_select        <= ptt_pkg::PTT_DECAY_NORMAL;
         peak_detect_cap_pf  <= 3'h1;
         high_pass_cap_pf    <= 3'h1;
         balance_gain_double <= 1'b0;
      end else if (!tune_on) begin
         dead_band_reduced   <= 1'b0;
         decay_select        <= ptt_pkg::PTT_DECAY_NORMAL;
         peak_detect_cap_pf  <= 3'h1;
         high_pass_cap_pf    <= 3'h1;
         balance_gain_double <= 1'b0;
      end else begin
         dead_band_reduced   <= phase_count_transient_tuning_q[grp * ptt_pkg::TU_STRIDE];
         case (raw_decay)
            2'h1: decay_select <= ptt_pkg::PTT_DECAY_NORMAL;
            2'h2: decay_select <= ptt_pkg::PTT_DECAY_QUARTER;
            default: decay_select <= ptt_pkg::PTT_DECAY_HALF;
         endcase
         peak_detect_cap_pf  <= {1'b0, phase_count_transient_tuning_q[ptt_pkg::TU_PEAK_LSB +: 2]} + 3'h1;
         high_pass_cap_pf    <= {1'b0, phase_count_transient_tuning_q[ptt_pkg::TU_HPASS_LSB +: 2]} + 3'h1;
         balance_gain_double <= phase_count_transient_tuning_q[ptt_pkg::TU_GAIN_BIT];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         current_monitor_pin_trim <= 5'h00;
      end else begin
         current_monitor_pin_trim <= current_monitor_zero_trim_q[4:0];
      end
   end

endmodule

// *** verification/ptt_regs_properties.sv ***
// concurrent checks on the protection and tuning register bank
// bound onto ptt_regs, sees only its ports
module ptt_regs_properties (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        cmd_write,
   input wire logic        cmd_read,
   input wire logic [15:0] cmd_rdata,
   input wire logic        cmd_ack,
   input wire logic        cmd_unmapped,
   input wire logic [8:0]  raw_fault,
   input wire logic [8:0]  fault_active,
   input wire logic        low_output_trip_event,
   input wire logic        hiccup_request,
   input wire logic [8:0]  low_output_trip_mv,
   input wire logic [8:0]  low_output_warning_level_mv,
   input wire logic [7:0]  transition_offset_mv,
   input wire logic        transition_offset_pulse,
   input wire logic [2:0]  peak_detect_cap_pf
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   chk_ack_follows: assert property ((cmd_write || cmd_read) |=> cmd_ack)
      else $error("ack missing after strobe");
   chk_ack_cause: assert property (cmd_ack |-> $past(cmd_write || cmd_read))
      else $error("ack without strobe");
   chk_unmapped_ack: assert property (cmd_unmapped |-> cmd_ack)
      else $error("unmapped flag without ack");
   chk_rdata_holds: assert property (!$past(cmd_read) |-> $stable(cmd_rdata))
      else $error("read data moved without read");
   chk_fault_quiet: assert property ((raw_fault == 9'h000) [*6] |-> fault_active == 9'h000)
      else $error("fault active with no raw fault");
   chk_trip_needs_raw: assert property ($rose(low_output_trip_event) |-> $past(raw_fault[5], 60))
      else $error("trip event before persistence");
   chk_hiccup_on_rise: assert property (hiccup_request |-> low_output_trip_event && !$past(low_output_trip_event))
      else $error("hiccup not on event rise");
   chk_trip_levels: assert property ((low_output_trip_mv != 9'h000) |-> low_output_trip_mv inside
      {9'h069, 9'h08d, 9'h0b2, 9'h0d6, 9'h0fc, 9'h123, 9'h148, 9'h192})
      else $error("trip level off table");
   chk_warn_above_trip: assert property ((low_output_trip_mv != 9'h000) |->
      low_output_warning_level_mv == low_output_trip_mv - 9'h042)
      else $error("warning level not 66 from trip");
   chk_offset_idle: assert property (!transition_offset_pulse |-> transition_offset_mv == 8'h00)
      else $error("offset outside pulse");
   chk_cap_range: assert property (peak_detect_cap_pf inside {[3'h1:3'h4]})
      else $error("peak cap out of range");
endmodule

bind ptt_regs ptt_regs_properties i_chk (
   .clock(clock), .rst(rst), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata),
   .cmd_ack(cmd_ack), .cmd_unmapped(cmd_unmapped), .raw_fault(raw_fault), .fault_active(fault_active),
   .low_output_trip_event(low_output_trip_event), .hiccup_request(hiccup_request),
   .low_output_trip_mv(low_output_trip_mv), .low_output_warning_level_mv(low_output_warning_level_mv),
   .transition_offset_mv(transition_offset_mv), .transition_offset_pulse(transition_offset_pulse),
   .peak_detect_cap_pf(peak_detect_cap_pf));

// *** verification/ptt_host.sv ***
// host model driving the command port of the register bank
// assumes strobes taken on the rising edge and ack one cycle later
module ptt_host (
   input  wire logic        clock,
   output logic             cmd_write,
   output logic             cmd_read,
   output logic      [7:0]  cmd_code,
   output logic      [15:0] cmd_wdata,
   input  wire logic [15:0] cmd_rdata,
   input  wire logic        cmd_ack,
   input  wire logic        cmd_unmapped
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmd_write = 1'b0;
      cmd_read = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // one-cycle strobe, released lines show the inverse of the last value
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] q, output logic u, output logic a);
      @(posedge clock);
      #10;
      cmd_write = w;
      cmd_read = !w;
      cmd_code = c;
      cmd_wdata = d;
      @(posedge clock);
      #10;
      cmd_write = 1'b0;
      cmd_read = 1'b0;
      cmd_code = ~c;
      cmd_wdata = ~d;
      q = cmd_rdata;
      u = cmd_unmapped;
      a = cmd_ack;
   endtask
endmodule

// *** verification/ptt_regs_test.sv ***
// self-checking bench for the protection and tuning register bank
// host model on the command port, loader and comparator inputs driven here
module ptt_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, rst, nvm_load_start, nvm_load_valid, event_q, hic_in, gain, db, u, a;
   logic        cmd_write, cmd_read, cmd_ack, cmd_unmapped, pulse;
   logic [15:0] cmd_wdata, cmd_rdata, nvm_load_data, q;
   logic [8:0]  raw_fault, fault_active, trip_mv, warn_mv;
   logic [7:0]  cmd_code, nvm_load_code, dcm_mv, decay_mv, ofs_mv, last_ofs;
   logic [6:0]  clamp_mv;
   logic [4:0]  trim;
   logic [2:0]  nonvolatile_bank_select, nvm_load_bank, speedup_sel, active_phase_count, peak, hpass;
   logic [1:0]  power_state, decay;
   int          miscompares, cmp_count, hic_cnt, ofs_cnt;
   logic [7:0]  codes [5] = '{8'hdf, 8'he1, 8'he2, 8'he3, 8'he4};
   logic [15:0] masks [5] = '{16'h01ff, 16'h007f, 16'h07ff, 16'h3fff, 16'h001f};
   logic [8:0]  lvl [8] = '{9'h069, 9'h08d, 9'h0b2, 9'h0d6, 9'h0fc, 9'h123, 9'h148, 9'h192};
   logic [1:0]  dec_exp [3] = '{2'h2, 2'h1, 2'h0};
   int          lim [4] = '{100, 200, 400, 1200};

   ptt_host i_host (.clock(clock), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_unmapped(cmd_unmapped));
   ptt_regs i_dut (.clock(clock), .rst(rst), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_unmapped(cmd_unmapped),
      .nonvolatile_bank_select(nonvolatile_bank_select), .nvm_load_start(nvm_load_start),
      .nvm_load_valid(nvm_load_valid), .nvm_load_code(nvm_load_code), .nvm_load_data(nvm_load_data),
      .nvm_load_bank(nvm_load_bank), .raw_fault(raw_fault), .fault_active(fault_active),
      .low_output_trip_event(event_q), .hiccup_request(hic_in), .low_output_trip_mv(trip_mv),
      .low_output_warning_level_mv(warn_mv), .speedup_sel(speedup_sel), .power_state(power_state),
      .active_phase_count(active_phase_count), .discontinuous_mode_offset_mv(dcm_mv),
      .compensation_voltage_clamp_mv(clamp_mv), .decay_comp_offset_mv(decay_mv),
      .transition_offset_mv(ofs_mv), .transition_offset_pulse(pulse), .dead_band_reduced(db),
      .decay_select(decay), .peak_detect_cap_pf(peak), .high_pass_cap_pf(hpass),
      .balance_gain_double(gain), .current_monitor_pin_trim(trim));

   initial clock = 1'b0;
   always #50 clock = ~clock;
   // remembers one-cycle pulses for later comparison
   always @(posedge clock) begin
      hic_cnt <= hic_cnt + int'(hic_in);
      ofs_cnt <= ofs_cnt + int'(pulse);
      if (pulse) last_ofs <= ofs_mv;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      i_host.xfer(1'b1, c, d, q, u, a);
      check(16'(a), 16'h0001, "ack");
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      i_host.xfer(1'b0, c, 16'h0000, q, u, a);
      check(q, exp, "read data");
   endtask
   task automatic complete_run;
      if (miscompares == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #(10000 * 100);
      miscompares++;
      complete_run;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {nvm_load_start, nvm_load_valid, nvm_load_code, nvm_load_data} = '0;
      {raw_fault, speedup_sel, power_state, active_phase_count, nonvolatile_bank_select} = '0;
      cyc(16);
      rst = 1'b0;
      check(16'(decay), 16'h0001, "decay reset");
      for (int i = 0; i < 5; i++) begin
         rd(codes[i], 16'h0000);
         wr(codes[i], 16'hffff);
         rd(codes[i], masks[i]);
      end
      wr(8'he0, 16'hffff);
      check(16'(u), 16'h0001, "unmapped");
      rd(8'he0, 16'h0000);
      {nonvolatile_bank_select, nvm_load_start} = {3'h5, 1'b1};
      cyc(1);
      {nvm_load_start, nvm_load_valid, nvm_load_code, nvm_load_data} = {1'b0, 1'b1, 8'hdf, 16'h0155};
      check(16'(nvm_load_bank), 16'h0005, "load bank");
      cyc(1);
      {nvm_load_valid, nvm_load_code, nvm_load_data} = {1'b0, 8'h20, 16'heaaa};
      rd(8'hdf, 16'h0155);
      for (int k = 0; k < 8; k++) begin
         wr(8'he1, 16'(k));
         cyc(2);
         check(16'(trip_mv), 16'(lvl[k]), "trip level");
         check(16'(warn_mv), 16'(lvl[k] - 9'h042), "warning level");
      end
      wr(8'hdf, 16'h010a);
      for (int k = 0; k < 4; k++) begin
         raw_fault = 9'h000;
         wr(8'he1, 16'((k << 4) | ((k == 0) << 6)));
         cyc(8);
         raw_fault = 9'h1ff;
         cyc(8);
         check(16'(fault_active), 16'h00f5, "fault active");
         cyc(lim[k] - 18);
         check(16'(event_q), 16'h0000, "event early");
         cyc(20);
         check(16'(event_q), 16'h0001, "event");
         check(16'(hic_cnt), 16'h0001, "hiccup");
      end
      wr(8'hdf, 16'h0120);
      cyc(6);
      check(16'(event_q), 16'h0000, "event masked");
      check(16'(fault_active), 16'h00df, "uv masked");
      raw_fault = 9'h000;
      wr(8'he2, 16'h07d8);
      cyc(2);
      check(16'(clamp_mv), 16'h0050, "clamp");
      check(16'(decay_mv), 16'h0064, "decay offset");
      check(16'(dcm_mv), 16'h0000, "dcm offset");
      power_state = 2'h2;
      cyc(3);
      check(16'(last_ofs), 16'h008c, "to lowest");
      power_state = 2'h1;
      cyc(3);
      check(16'(ofs_cnt), 16'h0001, "to reduced");
      power_state = 2'h0;
      cyc(3);
      check(16'(last_ofs), 16'h003c, "to full");
      wr(8'he3, 16'h3dd5);
      for (int p = 1; p < 4; p++) begin
         active_phase_count = 3'(p);
         cyc(3);
         check(16'(db), 16'(p != 2), "dead band");
         check(16'(decay), 16'(dec_exp[p - 1]), "decay");
         check({peak, hpass, 9'h000, gain}, 16'h7001, "caps gain");
      end
      speedup_sel = 3'h1;
      cyc(3);
      check({peak, hpass, 6'h00, db, decay, gain}, 16'h2402, "speedup defaults");
      wr(8'he4, 16'h0018);
      cyc(2);
      check(16'(trim), 16'h0018, "trim");
      complete_run;
   end
endmodule
